// *** hdl/afdc_top.sv ***
// Purpose: Automatic fan duty control for three PWM fans
// Assumes: Zone temperatures arrive as signed bytes with a sample strobe
// Notes: Registers reached over Avalon-MM, one byte per word
// How it works
// - Lock makes fan control registers read only, except manual duty writes
// - Ramp applies between start and start plus width
// - At start temperature run floor duty
// - Duty rises linearly across the ramp width
// - Above limit plus width run full duty
// - Rate code selects one of eight frequencies
// - Ramp code selects one of sixteen widths
// - Fractional widths reach full at next integer
// - Upper min-off bits choose per-fan below-limit action
// - Below limit: off, or floor when bit set
// - Per-zone bits enable spike smoothing
// - Window code selects averaging time
// - Readback shows raw temperature, not smoothed
// - Floor duty byte scales 00h to FFh
// - Start temperature is signed whole degrees
// - Above start, ramp uses fan's width code
// - Zone field selects auto, full, off, hottest, manual
// - Period of 256 steps, flip swaps levels
// - Fan stays at floor until below hysteresis
`timescale 1ns/1ps
`default_nettype none
module afdc_top
	import afdc_pkg::*;
(
	input wire logic CLK_IN,
	input wire logic RST_N_IN,
	input wire logic [9:0] AVS_ADDRESS_IN,
	input wire logic AVS_READ_IN,
	input wire logic AVS_WRITE_IN,
	input wire logic [31:0] AVS_WRITEDATA_IN,
	input wire logic [3:0] AVS_BYTEENABLE_IN,
	output logic [31:0] AVS_READDATA_OUT,
	output logic AVS_WAITREQUEST_OUT,
	input wire logic [23:0] ZONE_TEMP_IN,
	input wire logic TEMP_SAMPLE_IN,
	output logic [2:0] PWM_OUT
);
	function automatic logic [9:0] ba(input logic [7:0] idx);
		ba = {idx, 2'b00};
	endfunction : ba
	// Ramp width in whole degrees, rounded up for fractional entries
	function automatic logic [7:0] ramp_deg(input logic [3:0] code);
		ramp_deg = 8'((AFDC_RAMP_CDEG[code] + 99) / 100);
	endfunction : ramp_deg
	// Smoothing weight shift from window: longer window, heavier filter
	function automatic logic [3:0] sm_shift(input logic [2:0] code);
		sm_shift = 4'(3'd7 - code) + 4'(AFDC_SMOOTH_SHIFT) - 4'd3;
	endfunction : sm_shift
	logic [7:0] range_reg [3], range_next [3];
	logic [7:0] floor_reg [3], floor_next [3];
	logic [7:0] start_reg [3], start_next [3];
	logic [7:0] abs_reg [3], abs_next [3];
	logic [7:0] fancfg_reg [3], fancfg_next [3];
	logic [7:0] manual_reg [3], manual_next [3];
	logic [7:0] below_reg, below_next, sm23_reg, sm23_next;
	logic [7:0] hyst12_reg, hyst12_next, hyst3_reg, hyst3_next;
	logic lock_reg, lock_next;
	afdc_bus_e bus_reg, bus_next;
	logic [31:0] rdata_reg, rdata_next;
	logic [23:0] t_s1_reg, t_s2_reg;
	logic smp_s1_reg, smp_s2_reg, smp_s3_reg;
	logic [15:0] acc_reg [3], acc_next [3];
	logic [2:0] on_reg, on_next;
	logic [7:0] duty_reg [3], duty_next [3];
	logic smp_pulse;
	logic [7:0] zone_dut [3];
	logic signed [7:0] ctl_t [3];
	logic any_abs, any_auto;
	logic bus_wr, bus_rd;
	logic [2:0] flip_w, force_w;
	logic [2:0] zsel [3];
	assign smp_pulse = smp_s2_reg & ~smp_s3_reg;
	// Write commits at the edge where waitrequest is seen low
	assign bus_wr = (bus_reg == AFDC_BUS_ACK) && AVS_WRITE_IN && AVS_BYTEENABLE_IN[0];
	assign bus_rd = (bus_reg == AFDC_BUS_IDLE) && AVS_READ_IN;
	// Bus handshake: one wait cycle, answer on the second edge
	always_comb begin
		bus_next = bus_reg;
		case (bus_reg)
			AFDC_BUS_IDLE: begin
				if (AVS_READ_IN || AVS_WRITE_IN) begin
					bus_next = AFDC_BUS_ACK;
				end
			end
			AFDC_BUS_ACK: begin
				bus_next = AFDC_BUS_DONE;
			end
			AFDC_BUS_DONE: begin
				bus_next = AFDC_BUS_IDLE;
			end
			default: begin
				bus_next = AFDC_BUS_IDLE;
			end
		endcase
	end
	assign AVS_WAITREQUEST_OUT = (bus_reg != AFDC_BUS_ACK);
	assign AVS_READDATA_OUT = rdata_reg;
	// Register writes and reads
	always_comb begin
		below_next = below_reg;
		sm23_next = sm23_reg;
		hyst12_next = hyst12_reg;
		hyst3_next = hyst3_reg;
		lock_next = lock_reg;
		rdata_next = rdata_reg;
		for (int i = 0; i < 3; i++) begin
			range_next[i] = range_reg[i];
			floor_next[i] = floor_reg[i];
			start_next[i] = start_reg[i];
			abs_next[i] = abs_reg[i];
			fancfg_next[i] = fancfg_reg[i];
			manual_next[i] = manual_reg[i];
		end
		if (bus_wr) begin
			if (AVS_ADDRESS_IN == ba(AFDC_IDX_CTRL)) begin
				lock_next = lock_reg | AVS_WRITEDATA_IN[AFDC_LOCK_BIT];
			end else if (!lock_reg) begin
				for (int i = 0; i < 3; i++) begin
					if (AVS_ADDRESS_IN == ba(AFDC_IDX_RANGE1 + 8'(i))) begin
						range_next[i] = AVS_WRITEDATA_IN[7:0] & 8'hF7;
					end
					if (AVS_ADDRESS_IN == ba(AFDC_IDX_FLOOR1 + 8'(i))) begin
						floor_next[i] = AVS_WRITEDATA_IN[7:0];
					end
					if (AVS_ADDRESS_IN == ba(AFDC_IDX_START1 + 8'(i))) begin
						start_next[i] = AVS_WRITEDATA_IN[7:0];
					end
					if (AVS_ADDRESS_IN == ba(AFDC_IDX_ABS1 + 8'(i))) begin
						abs_next[i] = AVS_WRITEDATA_IN[7:0];
					end
					if (AVS_ADDRESS_IN == ba(AFDC_IDX_FANCFG1 + 8'(i))) begin
						fancfg_next[i] = AVS_WRITEDATA_IN[7:0] & 8'hF7;
					end
				end
				if (AVS_ADDRESS_IN == ba(AFDC_IDX_BELOW_SMOOTH1)) begin
					below_next = AVS_WRITEDATA_IN[7:0] & 8'hEF;
				end else if (AVS_ADDRESS_IN == ba(AFDC_IDX_SMOOTH23)) begin
					sm23_next = AVS_WRITEDATA_IN[7:0];
				end else if (AVS_ADDRESS_IN == ba(AFDC_IDX_HYST12)) begin
					hyst12_next = AVS_WRITEDATA_IN[7:0];
				end else if (AVS_ADDRESS_IN == ba(AFDC_IDX_HYST3)) begin
					hyst3_next = AVS_WRITEDATA_IN[7:0] & 8'hF0;
				end
			end
			for (int i = 0; i < 3; i++) begin
				if (AVS_ADDRESS_IN == ba(AFDC_IDX_DUTY1 + 8'(i)) && fancfg_reg[i][7:5] == 3'b111) begin
					manual_next[i] = AVS_WRITEDATA_IN[7:0];
				end
			end
		end
		if (bus_rd) begin
			rdata_next = 32'h00000000;
			for (int i = 0; i < 3; i++) begin
				if (AVS_ADDRESS_IN == ba(AFDC_IDX_RANGE1 + 8'(i))) rdata_next[7:0] = range_reg[i];
				if (AVS_ADDRESS_IN == ba(AFDC_IDX_FLOOR1 + 8'(i))) rdata_next[7:0] = floor_reg[i];
				if (AVS_ADDRESS_IN == ba(AFDC_IDX_START1 + 8'(i))) rdata_next[7:0] = start_reg[i];
				if (AVS_ADDRESS_IN == ba(AFDC_IDX_ABS1 + 8'(i))) rdata_next[7:0] = abs_reg[i];
				if (AVS_ADDRESS_IN == ba(AFDC_IDX_FANCFG1 + 8'(i))) rdata_next[7:0] = fancfg_reg[i];
				if (AVS_ADDRESS_IN == ba(AFDC_IDX_DUTY1 + 8'(i))) rdata_next[7:0] = duty_reg[i];
				if (AVS_ADDRESS_IN == ba(AFDC_IDX_TEMP1 + 8'(i))) rdata_next[7:0] = t_s2_reg[8*i +: 8];
			end
			if (AVS_ADDRESS_IN == ba(AFDC_IDX_BELOW_SMOOTH1)) begin
				rdata_next[7:0] = below_reg;
			end else if (AVS_ADDRESS_IN == ba(AFDC_IDX_SMOOTH23)) begin
				rdata_next[7:0] = sm23_reg;
			end else if (AVS_ADDRESS_IN == ba(AFDC_IDX_HYST12)) begin
				rdata_next[7:0] = hyst12_reg;
			end else if (AVS_ADDRESS_IN == ba(AFDC_IDX_HYST3)) begin
				rdata_next[7:0] = hyst3_reg;
			end else if (AVS_ADDRESS_IN == ba(AFDC_IDX_CTRL)) begin
				rdata_next[7:0] = {7'h00, lock_reg};
			end
		end
	end
	// Smoothing and per-fan duty computation
	always_comb begin
		logic [2:0] en;
		logic [2:0] wcode [3];
		logic signed [9:0] diff;
		logic signed [9:0] hlim;
		logic [7:0] width;
		logic [16:0] span;
		logic [7:0] zd;
		logic [3:0] hy [3];
		logic [2:0] zone;
		logic [7:0] best;
		en = {sm23_reg[AFDC_SM3_EN_BIT], sm23_reg[AFDC_SM2_EN_BIT], below_reg[AFDC_SM1_EN_BIT]};
		wcode[0] = below_reg[2:0];
		wcode[1] = sm23_reg[6:4];
		wcode[2] = sm23_reg[2:0];
		hy[0] = hyst12_reg[7:4];
		hy[1] = hyst12_reg[3:0];
		hy[2] = hyst3_reg[7:4];
		diff = 10'sd0;
		hlim = 10'sd0;
		width = 8'h00;
		span = 17'h00000;
		zd = 8'h00;
		zone = 3'b000;
		best = 8'h00;
		on_next = on_reg;
		any_abs = 1'b0;
		any_auto = 1'b0;
		for (int z = 0; z < 3; z++) begin
			acc_next[z] = acc_reg[z];
			if (smp_pulse) begin
				if (en[z]) begin
					acc_next[z] = 16'(acc_reg[z] - 16'($signed(acc_reg[z]) >>> sm_shift(wcode[z]))
						+ 16'($signed({{8{t_s2_reg[8*z+7]}}, t_s2_reg[8*z +: 8], 8'h00}) >>> sm_shift(wcode[z])));
				end else begin
					acc_next[z] = {t_s2_reg[8*z +: 8], 8'h00};
				end
			end
			// Use the freshly averaged value so duty tracks the current sample
			ctl_t[z] = $signed(acc_next[z][15:8]);
			if (abs_reg[z] != AFDC_ABS_OFF && ctl_t[z] > $signed(abs_reg[z])) begin
				any_abs = 1'b1;
			end
		end
		for (int f = 0; f < 3; f++) begin
			zsel[f] = fancfg_reg[f][7:5];
			if (zsel[f] <= 3'b010 || zsel[f] == 3'b101 || zsel[f] == 3'b110) any_auto = 1'b1;
		end
		for (int f = 0; f < 3; f++) begin
			duty_next[f] = duty_reg[f];
			best = 8'h00;
			for (int z = 0; z < 3; z++) begin
				// Duty that zone z would ask of fan f
				diff = 10'(ctl_t[z]) - 10'($signed(start_reg[z]));
				hlim = 10'(ctl_t[z]) - 10'($signed(start_reg[z])) + 10'(hy[z]);
				width = ramp_deg(range_reg[f][7:AFDC_RAMP_LSB]);
				if (diff >= 10'sd0) begin
					if (diff >= 10'(width)) begin
						zd = AFDC_DUTY_FULL;
					end else begin
						span = 17'(AFDC_DUTY_FULL - floor_reg[f]) * 17'(diff[8:0]);
						zd = 8'(17'(floor_reg[f]) + span / 17'(width));
					end
				end else if (below_reg[AFDC_KEEP_MIN_LSB + f] || (on_reg[f] && hlim >= 10'sd0)) begin
					zd = floor_reg[f];
				end else begin
					zd = 8'h00;
				end
				zone = zsel[f];
				if ((zone == 3'(z)) || (zone == 3'b101 && z != 0) || zone == 3'b110) begin
					if (zd > best) best = zd;
				end
			end
			if (smp_pulse) begin
				case (zsel[f])
					3'b011: duty_next[f] = AFDC_DUTY_FULL;
					3'b100: duty_next[f] = 8'h00;
					3'b111: duty_next[f] = any_abs && any_auto ? AFDC_DUTY_FULL : manual_reg[f];
					default: duty_next[f] = any_abs ? AFDC_DUTY_FULL : best;
				endcase
				on_next[f] = (duty_next[f] != 8'h00);
			end
			if (zsel[f] == 3'b111 && !smp_pulse) duty_next[f] = manual_reg[f];
		end
	end
	always_ff @(posedge CLK_IN) begin
		if (!RST_N_IN) begin
			bus_reg <= AFDC_BUS_IDLE;
			rdata_reg <= 32'h00000000;
			below_reg <= AFDC_RST_BELOW_SMOOTH;
			sm23_reg <= AFDC_RST_BELOW_SMOOTH;
			hyst12_reg <= AFDC_RST_HYST12;
			hyst3_reg <= AFDC_RST_HYST3;
			lock_reg <= 1'b0;
			t_s1_reg <= 24'h000000;
			t_s2_reg <= 24'h000000;
			smp_s1_reg <= 1'b0;
			smp_s2_reg <= 1'b0;
			smp_s3_reg <= 1'b0;
			on_reg <= 3'b000;
			for (int i = 0; i < 3; i++) begin
				range_reg[i] <= AFDC_RST_RANGE;
				floor_reg[i] <= AFDC_RST_FLOOR;
				start_reg[i] <= AFDC_RST_START;
				abs_reg[i] <= AFDC_RST_ABS;
				fancfg_reg[i] <= AFDC_RST_FANCFG;
				manual_reg[i] <= 8'h00;
				acc_reg[i] <= 16'h0000;
				duty_reg[i] <= 8'h00;
			end
		end else begin
			bus_reg <= bus_next;
			rdata_reg <= rdata_next;
			below_reg <= below_next;
			sm23_reg <= sm23_next;
			hyst12_reg <= hyst12_next;
			hyst3_reg <= hyst3_next;
			lock_reg <= lock_next;
			t_s1_reg <= ZONE_TEMP_IN;
			t_s2_reg <= t_s1_reg;
			smp_s1_reg <= TEMP_SAMPLE_IN;
			smp_s2_reg <= smp_s1_reg;
			smp_s3_reg <= smp_s2_reg;
			on_reg <= on_next;
			for (int i = 0; i < 3; i++) begin
				range_reg[i] <= range_next[i];
				floor_reg[i] <= floor_next[i];
				start_reg[i] <= start_next[i];
				abs_reg[i] <= abs_next[i];
				fancfg_reg[i] <= fancfg_next[i];
				manual_reg[i] <= manual_next[i];
				acc_reg[i] <= acc_next[i];
				duty_reg[i] <= duty_next[i];
			end
		end
	end
	for (genvar g = 0; g < 3; g++) begin : g_fan
		assign flip_w[g] = fancfg_reg[g][AFDC_FLIP_BIT];
		assign force_w[g] = (zsel[g] == 3'b100);
		afdc_pwm u_pwm (
			.clk_in(CLK_IN),
			.rst_n_in(RST_N_IN),
			.rate_in(range_reg[g][AFDC_RATE_LSB +: 3]),
			.duty_in(duty_reg[g]),
			.flip_in(flip_w[g]),
			.force_low_in(force_w[g]),
			.pwm_out(PWM_OUT[g])
		);
	end
endmodule : afdc_top
`default_nettype wire

// *** hdl/afdc_pkg.sv ***
// Purpose: Shared constants for the automatic fan duty block
// Assumes: Byte-wide registers, one per aligned 32-bit word
// Notes: Offsets are byte addresses (index times four)
package afdc_pkg;
	localparam logic [7:0] AFDC_IDX_RANGE1 = 8'h5F;
	localparam logic [7:0] AFDC_IDX_RANGE2 = 8'h60;
	localparam logic [7:0] AFDC_IDX_RANGE3 = 8'h61;
	localparam logic [7:0] AFDC_IDX_BELOW_SMOOTH1 = 8'h62;
	localparam logic [7:0] AFDC_IDX_SMOOTH23 = 8'h63;
	localparam logic [7:0] AFDC_IDX_FLOOR1 = 8'h64;
	localparam logic [7:0] AFDC_IDX_FLOOR2 = 8'h65;
	localparam logic [7:0] AFDC_IDX_FLOOR3 = 8'h66;
	localparam logic [7:0] AFDC_IDX_START1 = 8'h67;
	localparam logic [7:0] AFDC_IDX_START2 = 8'h68;
	localparam logic [7:0] AFDC_IDX_START3 = 8'h69;
	localparam logic [7:0] AFDC_IDX_ABS1 = 8'h6A;
	localparam logic [7:0] AFDC_IDX_HYST12 = 8'h6D;
	localparam logic [7:0] AFDC_IDX_HYST3 = 8'h6E;
	localparam logic [7:0] AFDC_IDX_FANCFG1 = 8'h5C;
	localparam logic [7:0] AFDC_IDX_CTRL = 8'h80;
	localparam logic [7:0] AFDC_IDX_TEMP1 = 8'h81;
	localparam logic [7:0] AFDC_IDX_DUTY1 = 8'h84;
	localparam logic [7:0] AFDC_RST_RANGE = 8'hC3;
	localparam logic [7:0] AFDC_RST_BELOW_SMOOTH = 8'h00;
	localparam logic [7:0] AFDC_RST_FLOOR = 8'h80;
	localparam logic [7:0] AFDC_RST_START = 8'h5A;
	localparam logic [7:0] AFDC_RST_ABS = 8'h64;
	localparam logic [7:0] AFDC_RST_HYST12 = 8'h44;
	localparam logic [7:0] AFDC_RST_HYST3 = 8'h40;
	localparam logic [7:0] AFDC_RST_FANCFG = 8'h62;
	localparam logic [7:0] AFDC_ABS_OFF = 8'h80;
	localparam int AFDC_RATE_LSB = 0;
	localparam int AFDC_RAMP_LSB = 4;
	localparam int AFDC_KEEP_MIN_LSB = 5;
	localparam int AFDC_SM1_EN_BIT = 3;
	localparam int AFDC_SM2_EN_BIT = 7;
	localparam int AFDC_SM3_EN_BIT = 3;
	localparam int AFDC_ZONE_LSB = 5;
	localparam int AFDC_FLIP_BIT = 4;
	localparam int AFDC_LOCK_BIT = 0;
	localparam logic [7:0] AFDC_DUTY_FULL = 8'hFF;
	localparam int AFDC_CLK_HZ = 25000000;
	localparam int AFDC_STEPS_PER_PERIOD = 256;
	// PWM frequency in centihertz per rate code
	localparam int AFDC_FREQ_CHZ [8] = '{1100, 1460, 2190, 2930, 3520, 4400, 5860, 8770};
	// Ramp width in hundredths of a degree per code
	localparam int AFDC_RAMP_CDEG [16] = '{200, 250, 333, 400, 500, 667, 800, 1000,
		1333, 1600, 2000, 2667, 3200, 4000, 5333, 8000};
	// Smoothing window in tenths of a second per code
	localparam int AFDC_SMOOTH_DS [8] = '{350, 176, 118, 70, 44, 30, 16, 8};
	localparam int AFDC_SMOOTH_SHIFT = 4;
	typedef enum logic [2:0] {
		AFDC_BUS_IDLE = 3'b001,
		AFDC_BUS_ACK = 3'b010,
		AFDC_BUS_DONE = 3'b100
	} afdc_bus_e;
endpackage : afdc_pkg

// *** hdl/afdc_pwm.sv ***
// Purpose: One fan PWM channel with selectable base rate
// Assumes: Duty 255 gives 255 high steps and one low step
// Notes: Step enable comes from a per-channel divider
`timescale 1ns/1ps
`default_nettype none
module afdc_pwm
	import afdc_pkg::*;
(
	input wire logic clk_in,
	input wire logic rst_n_in,
	input wire logic [2:0] rate_in,
	input wire logic [7:0] duty_in,
	input wire logic flip_in,
	input wire logic force_low_in,
	output logic pwm_out
);
	function automatic logic [19:0] step_div(input logic [2:0] code);
		step_div = 20'((AFDC_CLK_HZ / AFDC_STEPS_PER_PERIOD) * 100 / AFDC_FREQ_CHZ[code]);
	endfunction : step_div
	logic [19:0] div_reg, div_next;
	logic [7:0] step_reg, step_next;
	logic pwm_reg, pwm_next;
	always_comb begin
		div_next = div_reg + 20'h00001;
		step_next = step_reg;
		if (div_reg >= step_div(rate_in) - 20'h00001) begin
			div_next = 20'h00000;
			step_next = step_reg + 8'h01;
		end
		pwm_next = (step_reg < duty_in) & ~force_low_in;
		pwm_next = pwm_next ^ flip_in;
	end
	always_ff @(posedge clk_in) begin
		if (!rst_n_in) begin
			div_reg <= 20'h00000;
			step_reg <= 8'h00;
			pwm_reg <= 1'b0;
		end else begin
			div_reg <= div_next;
			step_reg <= step_next;
			pwm_reg <= pwm_next;
		end
	end
	assign pwm_out = pwm_reg;
endmodule : afdc_pwm
`default_nettype wire

// *** sim/afdc_properties.sv ***
// Purpose: Bus timing, read data and reset checks at the fan duty block ports
// Assumes: Master holds requests until waitrequest is low
// Notes: Bound to afdc_top
`timescale 1ns/1ps
`default_nettype none
module afdc_properties (
	input wire logic CLK_IN,
	input wire logic RST_N_IN,
	input wire logic [9:0] AVS_ADDRESS_IN,
	input wire logic AVS_READ_IN,
	input wire logic AVS_WRITE_IN,
	input wire logic [31:0] AVS_READDATA_OUT,
	input wire logic AVS_WAITREQUEST_OUT,
	input wire logic [2:0] PWM_OUT
);
	default clocking cb @(posedge CLK_IN); endclocking
	default disable iff (!RST_N_IN);
	sequence s_req_rise;
		$rose(AVS_READ_IN || AVS_WRITE_IN);
	endsequence
	sequence s_answer;
		!AVS_WAITREQUEST_OUT ##1 AVS_WAITREQUEST_OUT;
	endsequence
	property p_latency;
		s_req_rise |-> ##[1:3] s_answer;
	endproperty
	a_latency: assert property (p_latency) else $error("No answer to request");
	property p_wait_one;
		$fell(AVS_WAITREQUEST_OUT) |=> AVS_WAITREQUEST_OUT;
	endproperty
	a_wait_one: assert property (p_wait_one) else $error("Waitrequest low too long");
	property p_wait_needs_req;
		!AVS_WAITREQUEST_OUT |-> (AVS_READ_IN || AVS_WRITE_IN);
	endproperty
	a_wait_needs_req: assert property (p_wait_needs_req) else $error("Answer without request");
	property p_idle_wait;
		!AVS_READ_IN && !AVS_WRITE_IN |=> AVS_WAITREQUEST_OUT;
	endproperty
	a_idle_wait: assert property (p_idle_wait) else $error("Waitrequest low while idle");
	property p_rd_upper_zero;
		!AVS_WAITREQUEST_OUT && AVS_READ_IN |-> AVS_READDATA_OUT[31:8] == 24'h000000;
	endproperty
	a_rd_upper_zero: assert property (p_rd_upper_zero) else $error("Upper read bits set");
	property p_rd_stands;
		$changed(AVS_READDATA_OUT) |-> !AVS_WAITREQUEST_OUT && AVS_READ_IN;
	endproperty
	a_rd_stands: assert property (p_rd_stands) else $error("Read data moved outside a read");
	property p_unmapped_zero;
		!AVS_WAITREQUEST_OUT && AVS_READ_IN && AVS_ADDRESS_IN == 10'h1C0 |-> AVS_READDATA_OUT == 32'h00000000;
	endproperty
	a_unmapped_zero: assert property (p_unmapped_zero) else $error("Unmapped read not zero");
	property p_reset_release;
		$rose(RST_N_IN) |-> PWM_OUT == 3'h0 && AVS_WAITREQUEST_OUT;
	endproperty
	a_reset_release: assert property (p_reset_release) else $error("Outputs not idle after reset");
	c_read: cover property (AVS_READ_IN && !AVS_WAITREQUEST_OUT);
endmodule : afdc_properties
bind afdc_top afdc_properties u_props (.CLK_IN(CLK_IN), .RST_N_IN(RST_N_IN), .AVS_ADDRESS_IN(AVS_ADDRESS_IN),
	.AVS_READ_IN(AVS_READ_IN), .AVS_WRITE_IN(AVS_WRITE_IN), .AVS_READDATA_OUT(AVS_READDATA_OUT),
	.AVS_WAITREQUEST_OUT(AVS_WAITREQUEST_OUT), .PWM_OUT(PWM_OUT));
`default_nettype wire

// *** sim/afdc_fan_model.sv ***
// Purpose: Fan drive stand-in that notes when each PWM input goes high
// Assumes: Drive transistor conducts while PWM is high
// Notes: Flags clear only on reset
`timescale 1ns/1ps
`default_nettype none
module afdc_fan_model (
	input wire logic clk_in,
	input wire logic rst_n_in,
	input wire logic [2:0] pwm_in,
	output logic [2:0] driven_out
);
	always_ff @(posedge clk_in) begin
		if (!rst_n_in) begin
			driven_out <= 3'h0;
		end else begin
			driven_out <= driven_out | pwm_in;
		end
	end
endmodule : afdc_fan_model
`default_nettype wire

// *** sim/tb.sv ***
// Purpose: Register and duty checks for the automatic fan duty block
// Assumes: Duty settles within twelve cycles of a sample strobe
// Notes: Zones 2 and 3 held at 20 degrees
`timescale 1ns/1ps
`default_nettype none
module tb;
	import afdc_pkg::*;
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	logic [9:0] addr = 10'h000;
	logic rd_en = 1'b0;
	logic wr_en = 1'b0;
	logic [31:0] wdata = 32'h00000000;
	logic [3:0] be = 4'h0;
	logic [31:0] rdata;
	logic waitreq;
	logic [23:0] zone_temp = 24'h141414;
	logic sample = 1'b0;
	logic [2:0] pwm;
	logic [2:0] driven;
	logic [7:0] dummy;
	int err_count = 0;
	int compares = 0;
	logic [7:0] rst_tab [11] = '{8'hC3, 8'hC3, 8'hC3, 8'h00, 8'h00, 8'h80, 8'h80, 8'h80, 8'h5A, 8'h5A, 8'h5A};
	logic [7:0] t_tab [7] = '{8'h28, 8'h32, 8'h36, 8'h3A, 8'h46, 8'h2F, 8'h2D};
	logic [7:0] d_tab [7] = '{8'h00, 8'h80, 8'hBF, 8'hFF, 8'hFF, 8'h80, 8'h00};
	afdc_top dut (.CLK_IN(clk), .RST_N_IN(rst_n), .AVS_ADDRESS_IN(addr), .AVS_READ_IN(rd_en),
		.AVS_WRITE_IN(wr_en), .AVS_WRITEDATA_IN(wdata), .AVS_BYTEENABLE_IN(be), .AVS_READDATA_OUT(rdata),
		.AVS_WAITREQUEST_OUT(waitreq), .ZONE_TEMP_IN(zone_temp), .TEMP_SAMPLE_IN(sample), .PWM_OUT(pwm));
	afdc_fan_model fan (.clk_in(clk), .rst_n_in(rst_n), .pwm_in(pwm), .driven_out(driven));
	initial begin
		forever #20 clk = ~clk;
	end
	task finish_test;
		$display("Comparisons %0d mismatches %0d", compares, err_count);
		if (err_count == 0 && compares > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask : finish_test
	task chk(input logic [7:0] got, input logic [7:0] exp);
		compares++;
		if (got !== exp) begin
			err_count++;
			$display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk
	task bus(input logic wr, input logic [7:0] idx, input logic [7:0] d, input logic [3:0] ben,
		output logic [7:0] q);
		int n;
		@(posedge clk);
		wr_en <= wr;
		rd_en <= !wr;
		addr <= {idx, 2'b00};
		wdata <= {24'h000000, d};
		be <= ben;
		n = 0;
		do begin
			@(posedge clk);
			n++;
		end while (waitreq !== 1'b0 && n < 50);
		q = rdata[7:0];
		wr_en <= 1'b0;
		rd_en <= 1'b0;
		if (n >= 50) begin
			err_count++;
			$display("FAIL t=%0t got=%h exp=%h", $time, waitreq, 1'b0);
			finish_test();
		end
	endtask : bus
	task wr(input logic [7:0] idx, input logic [7:0] d);
		bus(1'b1, idx, d, 4'h1, dummy);
	endtask : wr
	task rdc(input logic [7:0] idx, input logic [7:0] exp);
		logic [7:0] q;
		bus(1'b0, idx, 8'h00, 4'hF, q);
		chk(q, exp);
	endtask : rdc
	task temp(input logic [7:0] t1);
		@(posedge clk);
		zone_temp <= {16'h1414, t1};
		sample <= 1'b1;
		@(posedge clk);
		sample <= 1'b0;
		repeat (12) @(posedge clk);
	endtask : temp
	initial begin
		repeat (6) @(posedge clk);
		rst_n <= 1'b1;
		for (int i = 0; i < 11; i++) begin
			rdc(8'h5F + 8'(i), rst_tab[i]);
		end
		rdc(8'h70, 8'h00);
		wr(8'h5C, 8'h00);
		wr(8'h5D, 8'h90);
		wr(8'h5E, 8'h80);
		wr(8'h67, 8'h32);
		wr(8'h5F, 8'h63);
		for (int i = 0; i < 7; i++) begin
			temp(t_tab[i]);
			rdc(8'h84, d_tab[i]);
		end
		wr(8'h62, 8'h20);
		temp(8'h1E);
		rdc(8'h84, 8'h80);
		wr(8'h62, 8'h08);
		temp(8'h46);
		rdc(8'h81, 8'h46);
		rdc(8'h84, 8'h00);
		wr(8'h62, 8'h00);
		temp(8'h46);
		rdc(8'h84, 8'hFF);
		wr(8'h5F, 8'h23);
		temp(8'h36);
		rdc(8'h84, 8'hFF);
		bus(1'b1, 8'h64, 8'h40, 4'h0, dummy);
		rdc(8'h64, 8'h80);
		wr(8'h5C, 8'hE0);
		wr(8'h84, 8'h5A);
		rdc(8'h84, 8'h5A);
		wr(8'h5C, 8'h60);
		temp(8'h1E);
		rdc(8'h84, 8'hFF);
		rdc(8'h86, 8'h00);
		chk({7'h00, pwm[2]}, 8'h00);
		chk({7'h00, driven[1]}, 8'h01);
		wr(8'h80, 8'h01);
		rdc(8'h80, 8'h01);
		wr(8'h64, 8'h11);
		rdc(8'h64, 8'h80);
		wr(8'h67, 8'h11);
		rdc(8'h67, 8'h32);
		wr(8'h5F, 8'h11);
		rdc(8'h5F, 8'h23);
		wr(8'h62, 8'hE0);
		rdc(8'h62, 8'h00);
		finish_test();
	end
endmodule : tb
`default_nettype wire
